// ==== ssel_capture_model.sv ====
module ssel_capture_model (
  input  wire logic pclk,     // line-locked clock
  input  wire logic presetn,  // async reset, low
  input  wire logic pin_oe,   // device drives the pin
  input  wire logic pin_o,    // device drive value
  output logic      pin_lvl,  // resolved pin level
  output logic      seen_q    // level captured each clock
);
  logic [4:0] lfsr_q;

  // a released pin wanders, so a stale sample cannot keep matching by luck
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lfsr_q <= 5'h1F;
    else lfsr_q <= {lfsr_q[3:0], lfsr_q[4] ^ lfsr_q[2]};
  end

  assign pin_lvl = pin_oe ? pin_o : lfsr_q[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seen_q <= 1'b0;
    else seen_q <= pin_lvl;
  end
endmodule

// ==== ssel_cfg.svh ====
`ifndef SSEL_CFG_SVH
`define SSEL_CFG_SVH
// Behaviour
// R1: select code is control register 12 bits 7:4
// R2: code 0 floats pin, samples aux input
// R3: code 1 drives converter LSB under bypass
// R4: code 2 drives general switch one level
// R5: code 3 horizontal lock, speed bit picks
// R6: software avoids fast lock with unstable sources
// R7: code 4 drives vertical and horizontal lock
// R8: code 5 drives lock plus colour detected
// R9: code 6 drives alternate line phase flag
// R10: code 7 drives horizontal valid reference
// R11: normal data types: reference high 1440 clocks
// R12: type 7: eight-clock begin/stop, fine delay
// R13: code 8 horizontal sync, two-clock delay steps
// R14: code 9 horizontal ref AND vertical ref
// R15: code 10 field identifier, high odd field
// R16: code 11 drives vertical sync pulse
// R17: code 12 drives alternative vertical pulse
// R18: code 13 vertical gate from start/stop lines
// R19: code 14 vertical reference, position bit picks
// R20: code 15 field flag, start line, polarity
// R21: pin registered; new code next clock

// register indices, byte address is four times the index
`define SSEL_IDX_HBEGIN   8'h06
`define SSEL_IDX_HSTOP    8'h07
`define SSEL_IDX_TIMING   8'h10
`define SSEL_IDX_DECODER  8'h11
`define SSEL_IDX_PINSEL   8'h12
`define SSEL_IDX_OUTCTL   8'h13
`define SSEL_IDX_VSTART   8'h15
`define SSEL_IDX_VSTOP    8'h16
`define SSEL_IDX_VMSB     8'h17
`define SSEL_IDX_STATUS   8'h1F

`define SSEL_RST_BYTE     8'h00
// field positions
`define SSEL_SEL_HI       7
`define SSEL_SEL_LO       4
`define SSEL_BYPASS_BIT   1
`define SSEL_LSPEED_BIT   4
`define SSEL_GSW1_BIT     7
`define SSEL_HDEL_HI      5
`define SSEL_HDEL_LO      4
`define SSEL_VREFPOS_BIT  3
`define SSEL_FIDPOL_BIT   3
`define SSEL_WINDOW_START_LINE_MSB_BIT    1
`define SSEL_WINDOW_STOP_LINE_MSB_BIT    0
// select codes
`define SSEL_C_TRISTATE   4'h0
`define SSEL_C_ADCLSB     4'h1
`define SSEL_C_GSW        4'h2
`define SSEL_C_HLOCK      4'h3
`define SSEL_C_VLOCK      4'h4
`define SSEL_C_DLOCK      4'h5
`define SSEL_C_PHASE      4'h6
`define SSEL_C_HORIZ_VALID_REFERENCE       4'h7
`define SSEL_C_HSYNC      4'h8
`define SSEL_C_GATED      4'h9
`define SSEL_C_ODD        4'hA
`define SSEL_C_VSYNC      4'hB
`define SSEL_C_VALT       4'hC
`define SSEL_C_VERTICAL_WINDOW_GATE      4'hD
`define SSEL_C_VREF       4'hE
`define SSEL_C_FID        4'hF
// horizontal timing
`define SSEL_RAW_TYPE     4'h7
`define SSEL_HORIZ_VALID_REFERENCE_LEN     12'h5A0
`define SSEL_HORIZ_VALID_REFERENCE_START   12'h000
`define SSEL_STEP_SHIFT   3
`define SSEL_FINE_SHIFT   1
`endif

// ==== ssel_pkg.sv ====
package ssel_pkg;
  // live indicators from the decoder core, all line-locked
  typedef struct packed {
    logic       horiz_lock_std;        // standard horizontal lock
    logic       horiz_lock_fast;       // fast horizontal lock
    logic       vert_horiz_lock_flag;  // vertical and horizontal lock
    logic       full_lock_colour_flag; // locks plus colour detected
    logic       alt_line_phase_flag;   // low on alternate-phase lines
    logic       adc_lsb;               // converter least significant bit
    logic       field_odd;             // high during odd field
    logic       vertical_sync_pulse;   // vertical sync
    logic       alt_vertical_pulse;    // alternative vertical pulse
    logic       vref_early;            // vertical reference, position 0
    logic       vref_late;             // vertical reference, position 1
    logic [3:0] line_type;             // data type of current line
    logic [11:0] h_pos;                // clock count within line
    logic [8:0] v_line;                // line count within field
  } ssel_video_t;
endpackage

// ==== ssel_top.sv ====
`include "ssel_cfg.svh"
module ssel_top (
  input  wire logic                 pclk,      // line-locked clock
  input  wire logic                 presetn,   // async reset, low
  input  wire logic                 psel,      // apb select
  input  wire logic                 penable,   // apb enable
  input  wire logic                 pwrite,    // apb direction
  input  wire logic [31:0]          paddr,     // apb byte address
  input  wire logic [31:0]          pwdata,    // apb write data
  output logic      [31:0]          prdata,    // apb read data
  output logic                      pready,    // apb ready
  output logic                      pslverr,   // apb unmapped address
  input  wire ssel_pkg::ssel_video_t video,    // decoder indicators
  input  wire logic                 pin_i,     // status pin level in
  output logic                      pin_o,     // status pin drive
  output logic                      pin_oe,    // status pin enable
  output logic                      aux_test_input // sampled pin as input
);
  import ssel_pkg::*;

  logic [7:0] hbegin_q, hstop_q, timing_q, decoder_q, pinsel_q;
  logic [7:0] outctl_q, vstart_q, vstop_q, vmsb_q;
  logic       pin_q, oe_q, aux_q, fid_q, ready_q, err_q;
  logic [31:0] rdata_q;
  logic [3:0]  sel;
  logic [7:0]  idx;
  logic        mapped;
  logic        wr_go;
  logic [1:0]  hdel;
  logic [8:0]  vsta, vsto;
  logic [11:0] hb, he;
  logic        horiz_valid_reference, hsync, vref, vertical_window_gate, lock_sel, drive;

  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i == `SSEL_IDX_HBEGIN) || (i == `SSEL_IDX_HSTOP) ||
                (i == `SSEL_IDX_TIMING) || (i == `SSEL_IDX_DECODER) ||
                (i == `SSEL_IDX_PINSEL) || (i == `SSEL_IDX_OUTCTL) ||
                (i == `SSEL_IDX_VSTART) || (i == `SSEL_IDX_VSTOP) ||
                (i == `SSEL_IDX_VMSB) || (i == `SSEL_IDX_STATUS);
  endfunction

  // window test used by both horizontal pulses
  function automatic logic in_window(input logic [11:0] p, input logic [11:0] b,
                                     input logic [11:0] e);
    in_window = (p >= b) && (p < e);
  endfunction

  assign idx    = paddr[9:2];
  assign mapped = is_mapped(idx) && (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h000000);
  assign wr_go  = psel && penable && ready_q && pwrite && mapped;
  assign sel    = pinsel_q[`SSEL_SEL_HI:`SSEL_SEL_LO]; // see R1
  assign hdel   = timing_q[`SSEL_HDEL_HI:`SSEL_HDEL_LO];
  assign vsta   = {vmsb_q[`SSEL_WINDOW_START_LINE_MSB_BIT], vstart_q};
  assign vsto   = {vmsb_q[`SSEL_WINDOW_STOP_LINE_MSB_BIT], vstop_q};

  // apb: no wait states, ready raised in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ready_q <= psel && !penable;
      err_q   <= psel && !penable && !mapped;
      if (psel && !penable) begin
        // refused addresses read zero, including misaligned hits
        unique case (mapped ? idx : 8'h00)
          `SSEL_IDX_HBEGIN:  rdata_q <= {24'h000000, hbegin_q};
          `SSEL_IDX_HSTOP:   rdata_q <= {24'h000000, hstop_q};
          `SSEL_IDX_TIMING:  rdata_q <= {24'h000000, timing_q};
          `SSEL_IDX_DECODER: rdata_q <= {24'h000000, decoder_q};
          `SSEL_IDX_PINSEL:  rdata_q <= {24'h000000, pinsel_q};
          `SSEL_IDX_OUTCTL:  rdata_q <= {24'h000000, outctl_q};
          `SSEL_IDX_VSTART:  rdata_q <= {24'h000000, vstart_q};
          `SSEL_IDX_VSTOP:   rdata_q <= {24'h000000, vstop_q};
          `SSEL_IDX_VMSB:    rdata_q <= {24'h000000, vmsb_q};
          `SSEL_IDX_STATUS:  rdata_q <= {29'h00000000, fid_q, oe_q, pin_q};
          default:           rdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  // register file; a new select code is live from the edge after the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hbegin_q  <= `SSEL_RST_BYTE;
      hstop_q   <= `SSEL_RST_BYTE;
      timing_q  <= `SSEL_RST_BYTE;
      decoder_q <= `SSEL_RST_BYTE;
      pinsel_q  <= `SSEL_RST_BYTE;
      outctl_q  <= `SSEL_RST_BYTE;
      vstart_q  <= `SSEL_RST_BYTE;
      vstop_q   <= `SSEL_RST_BYTE;
      vmsb_q    <= `SSEL_RST_BYTE;
    end else if (wr_go) begin
      unique case (idx)
        `SSEL_IDX_HBEGIN:  hbegin_q  <= pwdata[7:0];
        `SSEL_IDX_HSTOP:   hstop_q   <= pwdata[7:0];
        `SSEL_IDX_TIMING:  timing_q  <= pwdata[7:0];
        `SSEL_IDX_DECODER: decoder_q <= pwdata[7:0];
        `SSEL_IDX_PINSEL:  pinsel_q  <= pwdata[7:0]; // see R21
        `SSEL_IDX_OUTCTL:  outctl_q  <= pwdata[7:0];
        `SSEL_IDX_VSTART:  vstart_q  <= pwdata[7:0];
        `SSEL_IDX_VSTOP:   vstop_q   <= pwdata[7:0];
        `SSEL_IDX_VMSB:    vmsb_q    <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // horizontal pulses: begin/stop in eight-clock steps
  always_comb begin
    hb = {1'b0, hbegin_q, 3'b000} + {10'h000, hdel};           // see R12
    he = {1'b0, hstop_q, 3'b000} + {10'h000, hdel};
    if (video.line_type == `SSEL_RAW_TYPE)
      horiz_valid_reference = in_window(video.h_pos, hb, he);                    // see R12
    else
      horiz_valid_reference = in_window(video.h_pos, `SSEL_HORIZ_VALID_REFERENCE_START,
                       `SSEL_HORIZ_VALID_REFERENCE_START + `SSEL_HORIZ_VALID_REFERENCE_LEN);      // see R11
    // sync trims in two-clock steps, hence delay doubled
    hsync = in_window(video.h_pos, hb + {10'h000, hdel},
                      he + {10'h000, hdel});                    // see R13
  end

  assign vref  = timing_q[`SSEL_VREFPOS_BIT] ? video.vref_late : video.vref_early; // see R19
  assign vertical_window_gate = (video.v_line >= vsta) && (video.v_line < vsto);                 // see R18
  // fast indicator only meant for stable sources
  assign lock_sel = decoder_q[`SSEL_LSPEED_BIT] ? video.horiz_lock_fast
                                                : video.horiz_lock_std;          // see R5 R6

  // field flag: polarity applied, then latched at the window start line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      fid_q <= 1'b0;
    else if (video.v_line == vsta)
      fid_q <= video.field_odd ^ outctl_q[`SSEL_FIDPOL_BIT];   // see R20
  end

  // pin mux
  always_comb begin
    unique case (sel)
      `SSEL_C_TRISTATE: drive = 1'b0;
      `SSEL_C_ADCLSB:   drive = decoder_q[`SSEL_BYPASS_BIT] & video.adc_lsb; // see R3
      `SSEL_C_GSW:      drive = decoder_q[`SSEL_GSW1_BIT];                   // see R4
      `SSEL_C_HLOCK:    drive = lock_sel;                                    // see R5
      `SSEL_C_VLOCK:    drive = video.vert_horiz_lock_flag;                  // see R7
      `SSEL_C_DLOCK:    drive = video.full_lock_colour_flag;                 // see R8
      `SSEL_C_PHASE:    drive = video.alt_line_phase_flag;                   // see R9
      `SSEL_C_HORIZ_VALID_REFERENCE:     drive = horiz_valid_reference;                                        // see R10
      `SSEL_C_HSYNC:    drive = hsync;                                       // see R13
      `SSEL_C_GATED:    drive = horiz_valid_reference & vref;                                 // see R14
      `SSEL_C_ODD:      drive = video.field_odd;                             // see R15
      `SSEL_C_VSYNC:    drive = video.vertical_sync_pulse;                   // see R16
      `SSEL_C_VALT:     drive = video.alt_vertical_pulse;                    // see R17
      `SSEL_C_VERTICAL_WINDOW_GATE:    drive = vertical_window_gate;                                       // see R18
      `SSEL_C_VREF:     drive = vref;                                        // see R19
      `SSEL_C_FID:      drive = fid_q;                                       // see R20
    endcase
  end

  // reserved bypass-off slot drives low rather than floating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
      oe_q  <= 1'b0;
      aux_q <= 1'b0;
    end else begin
      pin_q <= drive;                                  // see R21
      oe_q  <= (sel != `SSEL_C_TRISTATE);              // see R2
      aux_q <= (sel == `SSEL_C_TRISTATE) ? pin_i : aux_q; // see R2
    end
  end

  assign prdata         = rdata_q;
  assign pready         = ready_q;
  assign pslverr        = err_q;
  assign pin_o          = pin_q;
  assign pin_oe         = oe_q;
  assign aux_test_input = aux_q;

  a_tristate_off: assert property (@(posedge pclk) disable iff (!presetn) // see R2
    (sel == `SSEL_C_TRISTATE) |=> !pin_oe) else $error("pin driven in tri-state code");
  a_drive_on: assert property (@(posedge pclk) disable iff (!presetn) // see R1
    (sel != `SSEL_C_TRISTATE) |=> pin_oe) else $error("pin not driven");
  a_aux_sample: assert property (@(posedge pclk) disable iff (!presetn) // see R2
    (sel == `SSEL_C_TRISTATE) |=> aux_test_input == $past(pin_i)) else $error("aux not sampled");
  a_gsw_level: assert property (@(posedge pclk) disable iff (!presetn) // see R4
    (sel == `SSEL_C_GSW) |=> pin_o == $past(decoder_q[`SSEL_GSW1_BIT])) else $error("gsw wrong");
  a_bypass_lsb: assert property (@(posedge pclk) disable iff (!presetn) // see R3
    (sel == `SSEL_C_ADCLSB && decoder_q[`SSEL_BYPASS_BIT]) |=> pin_o == $past(video.adc_lsb))
    else $error("lsb not driven");
  a_hlock_fast: assert property (@(posedge pclk) disable iff (!presetn) // see R5
    (sel == `SSEL_C_HLOCK && decoder_q[`SSEL_LSPEED_BIT]) |=> pin_o == $past(video.horiz_lock_fast))
    else $error("fast lock wrong");
  a_horiz_valid_reference_len: assert property (@(posedge pclk) disable iff (!presetn) // see R11
    (sel == `SSEL_C_HORIZ_VALID_REFERENCE && video.line_type != `SSEL_RAW_TYPE && video.h_pos == 12'h59F)
    |=> pin_o) else $error("horiz_valid_reference short");
  a_horiz_valid_reference_end: assert property (@(posedge pclk) disable iff (!presetn) // see R11
    (sel == `SSEL_C_HORIZ_VALID_REFERENCE && video.line_type != `SSEL_RAW_TYPE && video.h_pos == 12'h5A0)
    |=> !pin_o) else $error("horiz_valid_reference long");
  a_gated_and: assert property (@(posedge pclk) disable iff (!presetn) // see R14
    (sel == `SSEL_C_GATED) |=> pin_o == $past(horiz_valid_reference & vref)) else $error("gated wrong");
  a_sel_apply: assert property (@(posedge pclk) disable iff (!presetn) // see R21
    (wr_go && idx == `SSEL_IDX_PINSEL && pwdata[7:4] == `SSEL_C_GSW)
    ##1 (sel == `SSEL_C_GSW) |=> pin_o == $past(decoder_q[`SSEL_GSW1_BIT]))
    else $error("select not applied");
endmodule

// ==== status_pin_output_selector_tb.sv ====
`include "ssel_cfg.svh"
module status_pin_output_selector_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ssel_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic        pin_i, pin_o, pin_oe, aux_in, prev_pin, fflag;
  logic        byp, lspd, gsw, vpos, field_flag_polarity;
  logic [1:0]  hdel;
  logic [3:0]  code, lo;
  logic [7:0]  hb, hs;
  logic [8:0]  vsta, vsto;
  ssel_video_t video;
  int          err_count = 0, comparisons = 0, cycles = 0, seed = 32'h21EF;

  ssel_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .video(video), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .aux_test_input(aux_in));
  ssel_capture_model u_far (.pclk(pclk), .presetn(presetn), .pin_oe(pin_oe),
    .pin_o(pin_o), .pin_lvl(pin_i), .seen_q());

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      results;
    end
  end

  // pre-edge pin level, the value the aux register takes at that edge
  always @(posedge pclk) prev_pin <= pin_i;

  // flag latches while the line count sits on the window start
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) fflag <= 1'b0;
    else if (video.v_line === vsta) fflag <= video.field_odd ^ field_flag_polarity;
  end

  task automatic results;
    if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk_word(input string nm, input logic [31:0] ex, got);
    comparisons++;
    if (got !== ex) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic chk_pin(input string nm, input logic [1:0] ex, got);
    comparisons++;
    if (got !== ex) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", nm, ex, got);
    end
  endtask

  function automatic logic [31:0] ra(input logic [7:0] i);
    ra = {22'h0, i, 2'h0};
  endfunction

  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    {psel, pwrite} <= {1'b1, w};
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask

  task automatic cfg_rand;
    {byp, lspd, gsw, vpos, field_flag_polarity, hdel} = 7'($random(seed));
    {hb, hs, vsta, vsto} = 34'({$random(seed), $random(seed)});
    // fast lock is fine here: the synthetic source has a steady timebase
    apb(1'b1, ra(`SSEL_IDX_DECODER), {24'h0, gsw, 2'h0, lspd, 2'h0, byp, 1'b0});
    apb(1'b1, ra(`SSEL_IDX_TIMING), {26'h0, hdel, vpos, 3'h0});
    apb(1'b1, ra(`SSEL_IDX_HBEGIN), {24'h0, hb});
    apb(1'b1, ra(`SSEL_IDX_HSTOP), {24'h0, hs});
    apb(1'b1, ra(`SSEL_IDX_OUTCTL), {28'h0, field_flag_polarity, 3'h0});
    apb(1'b1, ra(`SSEL_IDX_VSTART), {24'h0, vsta[7:0]});
    apb(1'b1, ra(`SSEL_IDX_VSTOP), {24'h0, vsto[7:0]});
    apb(1'b1, ra(`SSEL_IDX_VMSB), {30'h0, vsta[8], vsto[8]});
  endtask

  task automatic vid_rand(input int k);
    ssel_video_t v;
    logic [63:0] r;
    r = {$random(seed), $random(seed)};
    v = r[35:0];
    if (k[0]) v.line_type = 4'h7;
    case (k[3:1])
      3'h0: v.h_pos = 12'h59F;
      3'h1: v.h_pos = 12'h5A0;
      3'h2: v.h_pos = {1'b0, hb, 3'h0} + {10'h0, hdel};
      3'h3: v.h_pos = {1'b0, hs, 3'h0} + {9'h0, hdel, 1'b0} - 12'h1;
      3'h4: v.v_line = vsta;
      3'h5: v.v_line = vsto;
      default: ;
    endcase
    video <= v;
  endtask

  function automatic logic exp_pin(input logic [3:0] c, input ssel_video_t v);
    logic hr, vr;
    logic [11:0] b, e;
    b = {1'b0, hb, 3'h0} + {10'h0, hdel};
    e = {1'b0, hs, 3'h0} + {10'h0, hdel};
    vr = vpos ? v.vref_late : v.vref_early;
    if (v.line_type == 4'h7) hr = v.h_pos >= b && v.h_pos < e;
    else hr = v.h_pos < 12'h5A0;
    case (c)
      4'h1: exp_pin = byp & v.adc_lsb;
      4'h2: exp_pin = gsw;
      4'h3: exp_pin = lspd ? v.horiz_lock_fast : v.horiz_lock_std;
      4'h4: exp_pin = v.vert_horiz_lock_flag;
      4'h5: exp_pin = v.full_lock_colour_flag;
      4'h6: exp_pin = v.alt_line_phase_flag;
      4'h7: exp_pin = hr;
      4'h8: exp_pin = v.h_pos >= b + {10'h0, hdel} && v.h_pos < e + {10'h0, hdel};
      4'h9: exp_pin = hr & vr;
      4'hA: exp_pin = v.field_odd;
      4'hB: exp_pin = v.vertical_sync_pulse;
      4'hC: exp_pin = v.alt_vertical_pulse;
      4'hD: exp_pin = v.v_line >= vsta && v.v_line < vsto;
      4'hE: exp_pin = vr;
      default: exp_pin = fflag;
    endcase
  endfunction

  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    video = 36'h0;
    repeat (6) @(posedge pclk);
    chk_pin("pin in reset", 2'h0, {pin_oe, aux_in});
    presetn <= 1'b1;
    apb(1'b0, ra(`SSEL_IDX_PINSEL), 32'h0);
    chk_word("select reset", 32'h0, rd);
    apb(1'b1, 32'h49, 32'hF0);
    chk_word("misaligned err", 32'h1, {31'h0, er});
    apb(1'b0, 32'h0, 32'h0);
    chk_word("unmapped err", 32'h1, {31'h0, er});
    for (int c = 0; c < 16; c++) begin
      cfg_rand;
      code = c[3:0];
      lo = 4'($random(seed));
      apb(1'b1, ra(`SSEL_IDX_PINSEL), {24'h0, code, lo});
      for (int k = 0; k < 13; k++) begin
        if (k > 0) @(posedge pclk);
        if (k > 0) vid_rand(k);
        repeat (k > 0 ? 2 : 1) @(posedge pclk);
        #1;
        if (code == 4'h0) chk_pin("floated pin", {1'b0, prev_pin}, {pin_oe, aux_in});
        else chk_pin("driven pin", {1'b1, exp_pin(code, video)}, {pin_oe, pin_o});
      end
      apb(1'b0, ra(`SSEL_IDX_PINSEL), 32'h0);
      chk_word("select readback", {24'h0, code, lo}, rd);
    end
    results;
  end
endmodule
